// [seee_pkg.sv]
// Constants of the serial EEPROM command logic
package seee_pkg;
    // Opcodes after the start bit
    localparam logic [1:0] OP_EXT = 2'h0;
    localparam logic [1:0] OP_WRITE = 2'h1;
    localparam logic [1:0] OP_READ = 2'h2;
    localparam logic [1:0] OP_ERASE = 2'h3;
    // Extended codes in the two top address bits
    localparam logic [1:0] EXT_LOCK = 2'h0;
    localparam logic [1:0] EXT_FILL = 2'h1;
    localparam logic [1:0] EXT_BULK = 2'h2;
    localparam logic [1:0] EXT_UNLOCK = 2'h3;
    localparam int START_OPC_BITS = 3;
    localparam logic [7:0] ERASED_BYTE = 8'hff;
    // Timing
    localparam int CLK_PERIOD_NS = 100;
    localparam int DESELECT_MIN_TIME_NS = 200;
    localparam int DESELECT_MIN_CYC = (DESELECT_MIN_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int PROG_TIME_NS = 5000000;
    localparam int PROG_CYC_DEFAULT = PROG_TIME_NS / CLK_PERIOD_NS;
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_SHIFT = 2'b01,
        ST_BUSY = 2'b10
    } seee_state_t;
endpackage

// [seee_core.sv]
// Command decoder, erase engine, ready/busy and clock-pulse check of a serial EEPROM
`timescale 1ns/1ps
`default_nettype none

// What this block does
// - An erase of one location sets every bit of it to one, starting when select falls after a well-formed frame.
// - Bulk erase sets the whole array to one after a dummy address, otherwise like a single erase.
// - During a self-timed cycle the serial output shows low while select is high, after the deselect delay.
// - During a self-timed cycle all serial input bits are ignored.
// - After the cycle ends the output shows high while select is high, until select falls or a start bit arrives.
// - Clock edges are counted from the start bit to select falling, and a wrong count aborts a modifying command.
// - The expected count is start plus opcode plus address bits, plus data bits for write and fill.
// - The array starts as all ones.
// - Modifying commands run only after unlock, and lock disables them again.
// - After reset modifying commands are disabled.
// - The serial input is sampled on each rising serial clock edge while select is high, except during a self-timed cycle.
module seee_core
    import seee_pkg::*;
#(
    parameter int ADDR_W = 9,
    parameter int DATA_W = 8,
    parameter int PROG_CYC = PROG_CYC_DEFAULT
) (
    // Clock and reset
    input wire logic CLK_SYS_I,
    input wire logic RESET_I,
    // Serial link
    input wire logic SEL_I,
    input wire logic SCLK_I,
    input wire logic SDI_I,
    output logic SDO_O,
    output logic SDO_OE_O,
    // Status
    output logic BUSY_O,
    output logic PROG_EN_O
);
    localparam int DEPTH = 1 << ADDR_W;
    localparam int CNT_W = 8;
    localparam int TMR_W = 32;
    localparam logic [CNT_W-1:0] N_ERASE = CNT_W'(START_OPC_BITS + ADDR_W);
    localparam logic [CNT_W-1:0] N_WRITE = CNT_W'(START_OPC_BITS + ADDR_W + DATA_W);

    logic [DATA_W-1:0] mem [DEPTH];

    // Input synchronisers
    logic [1:0] sel_sync_ff, clk_sync_ff, din_sync_ff;
    logic clk_prev_ff, sel_prev_ff;
    always_ff @(posedge CLK_SYS_I or posedge RESET_I) begin
        if (RESET_I) begin
            sel_sync_ff <= 2'h0;
            clk_sync_ff <= 2'h0;
            din_sync_ff <= 2'h0;
            clk_prev_ff <= 1'b0;
            sel_prev_ff <= 1'b0;
        end else begin
            sel_sync_ff <= {sel_sync_ff[0], SEL_I};
            clk_sync_ff <= {clk_sync_ff[0], SCLK_I};
            din_sync_ff <= {din_sync_ff[0], SDI_I};
            clk_prev_ff <= clk_sync_ff[1];
            sel_prev_ff <= sel_sync_ff[1];
        end
    end
    wire sel = sel_sync_ff[1];
    wire din = din_sync_ff[1];
    wire clk_rise = clk_sync_ff[1] & ~clk_prev_ff;
    wire sel_fall = sel_prev_ff & ~sel;
    wire sel_rise = sel & ~sel_prev_ff;

    // Sequencer state; busy_ff mirrors the busy state so the port comes from a flop
    seee_state_t state_ff, nxt_state;
    logic busy_ff;
    logic started_ff;
    logic [CNT_W-1:0] cnt_ff;
    logic [ADDR_W+1:0] sreg_ff;
    logic [DATA_W-1:0] dreg_ff;
    logic prog_en_ff;
    logic [TMR_W-1:0] tmr_ff;
    logic [1:0] job_ff;
    logic [ADDR_W-1:0] job_addr_ff;
    logic [DATA_W-1:0] job_data_ff;
    logic [1:0] dsel_ff;
    logic ready_ff;
    logic sdo_ff, sdo_oe_ff;

    // Frame decoding, opcode in the two bits after the start bit
    wire [1:0] opc = sreg_ff[ADDR_W+1:ADDR_W];
    wire [ADDR_W-1:0] addr = sreg_ff[ADDR_W-1:0];
    wire [1:0] ext = sreg_ff[ADDR_W-1:ADDR_W-2];
    wire is_erase = opc == OP_ERASE;
    wire is_write = opc == OP_WRITE;
    wire is_fill = (opc == OP_EXT) && (ext == EXT_FILL);
    wire is_bulk = (opc == OP_EXT) && (ext == EXT_BULK);
    wire is_unlock = (opc == OP_EXT) && (ext == EXT_UNLOCK);
    wire is_lock = (opc == OP_EXT) && (ext == EXT_LOCK);
    wire long_cmd = is_write | is_fill;
    wire [CNT_W-1:0] expect_cnt = long_cmd ? N_WRITE : N_ERASE;
    wire count_ok = cnt_ff == expect_cnt;
    wire modify = is_erase | is_bulk | long_cmd;
    wire launch = (state_ff == ST_SHIFT) && sel_fall && modify && count_ok && prog_en_ff;
    wire tmr_done = tmr_ff == TMR_W'(PROG_CYC - 1);
    wire bit_in = (state_ff != ST_BUSY) && sel && clk_rise;
    wire new_start = (state_ff == ST_IDLE) && bit_in && din;

    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            ST_IDLE: if (new_start) nxt_state = ST_SHIFT;
            ST_SHIFT: begin
                if (launch) nxt_state = ST_BUSY;
                else if (!sel) nxt_state = ST_IDLE;
            end
            ST_BUSY: if (tmr_done) nxt_state = ST_IDLE;
            default: nxt_state = ST_IDLE;
        endcase
    end

    // Shift and count clock pulses from the start bit
    always_ff @(posedge CLK_SYS_I or posedge RESET_I) begin
        if (RESET_I) begin
            state_ff <= ST_IDLE;
            busy_ff <= 1'b0;
            cnt_ff <= '0;
            sreg_ff <= '0;
            dreg_ff <= '0;
            started_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            busy_ff <= (nxt_state == ST_BUSY);
            // A zero while idle is not a start bit, so leading zeros are skipped
            if (new_start) begin
                cnt_ff <= CNT_W'(1);
                started_ff <= 1'b1;
            end else if (state_ff == ST_SHIFT && bit_in) begin
                if (cnt_ff != '1) cnt_ff <= cnt_ff + CNT_W'(1);
                if (cnt_ff < N_ERASE) sreg_ff <= {sreg_ff[ADDR_W:0], din};
                else dreg_ff <= {dreg_ff[DATA_W-2:0], din};
            end else if (state_ff != ST_SHIFT) begin
                started_ff <= 1'b0;
            end
        end
    end

    // Program enable, cleared by reset
    always_ff @(posedge CLK_SYS_I or posedge RESET_I) begin
        if (RESET_I) prog_en_ff <= 1'b0;
        else if (state_ff == ST_SHIFT && sel_fall && count_ok) begin
            if (is_unlock) prog_en_ff <= 1'b1;
            else if (is_lock) prog_en_ff <= 1'b0;
        end
    end

    // Self-timed cycle
    always_ff @(posedge CLK_SYS_I or posedge RESET_I) begin
        if (RESET_I) begin
            tmr_ff <= '0;
            job_ff <= OP_EXT;
            job_addr_ff <= '0;
            job_data_ff <= '0;
        end else if (launch) begin
            tmr_ff <= '0;
            job_ff <= is_bulk ? EXT_BULK : (is_fill ? EXT_FILL : opc);
            job_addr_ff <= addr;
            job_data_ff <= dreg_ff;
        end else if (state_ff == ST_BUSY && !tmr_done) begin
            tmr_ff <= tmr_ff + TMR_W'(1);
        end
    end

    // Array update at the end of the cycle
    // Nothing is written before the timer expires, so an aborted or reset
    // cycle leaves the array as it was
    wire commit = (state_ff == ST_BUSY) && tmr_done;
    always_ff @(posedge CLK_SYS_I) begin
        if (commit) begin
            for (int i = 0; i < DEPTH; i++) begin
                if (job_ff == EXT_BULK || job_ff == EXT_FILL
                    || ADDR_W'(i) == job_addr_ff) begin
                    if (job_ff == OP_WRITE || job_ff == EXT_FILL) mem[i] <= job_data_ff;
                    else if (job_ff == EXT_BULK || job_ff == OP_ERASE) mem[i] <= '1;
                end
            end
        end
    end

    initial begin
        for (int i = 0; i < DEPTH; i++) mem[i] = {(DATA_W/8){ERASED_BYTE}};
    end

    // Ready/busy on the serial output
    // Busy status only appears once select has been high for the deselect delay, ready status one cycle after select rises,
    // and the output is released whenever select is low
    always_ff @(posedge CLK_SYS_I or posedge RESET_I) begin
        if (RESET_I) begin
            dsel_ff <= '0;
            ready_ff <= 1'b0;
            sdo_ff <= 1'b0;
            sdo_oe_ff <= 1'b0;
        end else begin
            if (!sel) dsel_ff <= '0;
            else if (dsel_ff != 2'(DESELECT_MIN_CYC)) dsel_ff <= dsel_ff + 2'h1;
            if (commit) ready_ff <= 1'b1;
            else if (sel_fall || new_start) ready_ff <= 1'b0;
            if (state_ff == ST_BUSY && sel && dsel_ff == 2'(DESELECT_MIN_CYC)) begin
                sdo_ff <= 1'b0;
                sdo_oe_ff <= 1'b1;
            end else if (ready_ff && sel && !new_start && !sel_rise) begin
                sdo_ff <= 1'b1;
                sdo_oe_ff <= 1'b1;
            end else begin
                sdo_ff <= 1'b0;
                sdo_oe_ff <= 1'b0;
            end
        end
    end

    assign SDO_O = sdo_ff;
    assign SDO_OE_O = sdo_oe_ff;
    assign BUSY_O = busy_ff;
    assign PROG_EN_O = prog_en_ff;
endmodule
`default_nettype wire

// [seee_core_sva.sv]
// Port assertions for the serial EEPROM command logic
`timescale 1ns/1ps
`default_nettype none
module seee_core_sva #(parameter int PROG_CYC = 20) (
    input wire logic CLK_SYS_I, RESET_I, SEL_I, SCLK_I, SDI_I,
    input wire logic SDO_O, SDO_OE_O, BUSY_O, PROG_EN_O
);
    int unsigned cnt_ff;
    always_ff @(posedge CLK_SYS_I or posedge RESET_I) begin
        if (RESET_I) cnt_ff <= 0;
        else cnt_ff <= BUSY_O ? cnt_ff + 1 : 0;
    end
    default clocking @(posedge CLK_SYS_I); endclocking
    default disable iff (RESET_I);
    a_quiet_off: assert property (!SDO_OE_O |-> !SDO_O)
        else $error("output high while undriven");
    a_busy_low: assert property (BUSY_O && $past(BUSY_O) && SDO_OE_O |-> !SDO_O)
        else $error("ready shown while busy");
    a_busy_len: assert property ($fell(BUSY_O) |-> cnt_ff >= PROG_CYC && cnt_ff <= PROG_CYC + 1)
        else $error("busy length wrong");
    a_oe_drop: assert property ($fell(SEL_I) |-> ##[1:5] !SDO_OE_O)
        else $error("status kept after deselect");
    a_ready_high: assert property (SDO_OE_O && !BUSY_O && !$past(BUSY_O) |-> SDO_O)
        else $error("ready not shown");
    a_start_desel: assert property ($rose(BUSY_O) |-> !SEL_I && !$past(SEL_I))
        else $error("cycle started while selected");
    a_start_en: assert property ($rose(BUSY_O) |-> PROG_EN_O)
        else $error("cycle started while locked");
    a_en_busy: assert property (BUSY_O |-> $stable(PROG_EN_O))
        else $error("enable changed while busy");
    a_reset_lock: assert property ($fell(RESET_I) |-> !PROG_EN_O)
        else $error("enabled after reset");
    cover property ($rose(BUSY_O));
    cover property (SDO_OE_O && SDO_O);
    cover property ($fell(PROG_EN_O));
endmodule
`default_nettype wire

// [seee_master.sv]
// Bus master model driving select, serial clock and data
`timescale 1ns/1ps
`default_nettype none
module seee_master (
    input wire logic clk_i,
    input wire logic sdo_i,
    output logic sel_o,
    output logic sclk_o,
    output logic sdi_o
);
    initial begin
        sel_o = 0;
        sclk_o = 0;
        sdi_o = 0;
    end
    // MSB first, one bit per 800 ns clock; clock idles low between frames
    task automatic frame(input logic [19:0] bits, input int n);
        @(negedge clk_i) sel_o = 1;
        repeat (4) @(negedge clk_i);
        for (int i = n - 1; i >= 0; i--) begin
            sdi_o = bits[i];
            repeat (4) @(negedge clk_i);
            sclk_o = 1;
            repeat (4) @(negedge clk_i);
            sclk_o = 0;
        end
        repeat (2) @(negedge clk_i);
        sel_o = 0;
        sdi_o = ~sdi_o;
        repeat (8) @(negedge clk_i);
    endtask
    task automatic poll(output logic ok);
        ok = 0;
        @(negedge clk_i) sel_o = 1;
        repeat (400) begin
            @(negedge clk_i);
            if (sdo_i === 1'b1) begin
                ok = 1;
                break;
            end
        end
    endtask
    task automatic drop();
        sel_o = 0;
        repeat (8) @(negedge clk_i);
    endtask
endmodule
`default_nettype wire

// [serial_eeprom_erase_status_bench.sv]
// Bench for the serial EEPROM command logic
`timescale 1ns/1ps
`default_nettype none
module serial_eeprom_erase_status_bench;
    import seee_pkg::*;
    localparam logic [19:0] F_ER = {8'h0, 1'b1, OP_ERASE, 9'h0a5};
    localparam logic [19:0] F_UN = {8'h0, 1'b1, OP_EXT, EXT_UNLOCK, 7'h00};
    localparam logic [19:0] F_LK = {8'h0, 1'b1, OP_EXT, EXT_LOCK, 7'h00};
    localparam logic [19:0] F_BK = {8'h0, 1'b1, OP_EXT, EXT_BULK, 7'h00};
    localparam logic [19:0] F_WR = {1'b1, OP_WRITE, 9'h033, 8'h5a};
    localparam logic [19:0] F_FL = {1'b1, OP_EXT, EXT_FILL, 7'h00, 8'h3c};
    logic clk = 0;
    logic rst = 1;
    logic ok;
    wire logic sel, sclk, sdi, sdo, oe, busy, en;
    int fails = 0;
    int n_tests = 0;
    always #50 clk = ~clk;
    seee_master m (.clk_i(clk), .sdo_i(sdo), .sel_o(sel), .sclk_o(sclk), .sdi_o(sdi));
    seee_core #(.PROG_CYC(200)) DUT (.CLK_SYS_I(clk), .RESET_I(rst), .SEL_I(sel),
        .SCLK_I(sclk), .SDI_I(sdi), .SDO_O(sdo), .SDO_OE_O(oe), .BUSY_O(busy), .PROG_EN_O(en));
    task automatic chk(input logic seen, input logic exp);
        n_tests++;
        if (seen !== exp) begin
            fails++;
            $display("CHECK FAILED %0t saw %b want %b", $time, seen, exp);
        end
    endtask
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task automatic cmd(input logic [19:0] f, input int n, input logic exp);
        m.frame(f, n);
        chk(busy, exp);
    endtask
    task automatic ready();
        m.poll(ok);
        chk(ok, 1);
        repeat (3) @(negedge clk);
        chk(sdo & oe, 1);
        m.drop();
        chk(oe, 0);
    endtask
    task automatic t_erase();
        cmd(F_ER, 12, 1);
        @(negedge clk) m.sel_o = 1;
        repeat (6) @(negedge clk);
        chk(oe & ~sdo, 1);
        m.drop();
        cmd(F_LK, 12, 1);
        chk(en, 1);
        ready();
    endtask
    initial begin
        repeat (4) @(negedge clk);
        rst = 0;
        chk(en | busy | oe, 0);
        cmd(F_ER, 12, 0);
        cmd(F_UN, 12, 0);
        chk(en, 1);
        cmd(F_ER, 11, 0);
        cmd({F_ER[18:0], 1'b0}, 13, 0);
        cmd(F_WR, 19, 0);
        t_erase();
        cmd(F_BK, 12, 1);
        ready();
        cmd(F_WR, 20, 1);
        ready();
        cmd(F_FL, 20, 1);
        ready();
        cmd(F_LK, 12, 0);
        chk(en, 0);
        cmd(F_BK, 12, 0);
        wrap_up();
    end
    initial begin
        #3000000;
        fails++;
        wrap_up();
    end
endmodule
bind seee_core seee_core_sva #(.PROG_CYC(PROG_CYC)) u_sva (.CLK_SYS_I(CLK_SYS_I),
    .RESET_I(RESET_I), .SEL_I(SEL_I), .SCLK_I(SCLK_I), .SDI_I(SDI_I), .SDO_O(SDO_O),
    .SDO_OE_O(SDO_OE_O), .BUSY_O(BUSY_O), .PROG_EN_O(PROG_EN_O));
`default_nettype wire
